// ===== logic/nibble_exec_pkg.sv
// shared opcodes, field layout, reset values and timing counts of the nibble executor
package nibble_exec_pkg;

	// ====================
	// data widths
	localparam int unsigned NIBBLE_W = 4;
	localparam int unsigned ROM_W    = 10;
	localparam int unsigned BITSEL_W = 2;

	// ====================
	// table word field layout
	localparam int unsigned ROM_ACC_LSB = 0;
	localparam int unsigned ROM_MID_LSB = 4;
	localparam int unsigned ROM_TOP_LSB = 8;
	localparam int unsigned ROM_TOP_W   = 2;

	// ====================
	// reset values
	localparam logic [3:0] ACC_RESET   = 4'h0;
	localparam logic       CARRY_RESET = 1'b0;
	localparam logic       ZERO_RESET  = 1'b0;
	localparam logic [3:0] MID_RESET   = 4'h0;
	localparam logic [3:0] TOP_RESET   = 4'h0;

	// ====================
	// timing counts in instruction cycles
	localparam int unsigned CYCLES_SINGLE     = 1;
	localparam int unsigned CYCLES_TABLE_READ = 3;

	// ====================
	// opcodes presented on the instruction port
	typedef enum logic [4:0] {
		OP_NOP                        = 5'h00,
		OP_ADD_LITERAL_WITH_CARRY     = 5'h01,
		OP_XOR_LITERAL                = 5'h02,
		OP_AND_LITERAL                = 5'h03,
		OP_OR_LITERAL                 = 5'h04,
		OP_LOAD_LITERAL_ACC           = 5'h05,
		OP_ROTATE_LEFT_PLAIN          = 5'h06,
		OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h07,
		OP_ROTATE_LEFT_THROUGH_CARRY  = 5'h08,
		OP_CLEAR_CARRY                = 5'h09,
		OP_SET_CARRY                  = 5'h0A,
		OP_INCREMENT_ACCUMULATOR      = 5'h0B,
		OP_DECREMENT_ACCUMULATOR      = 5'h0C,
		OP_SKIP_IF_ABOVE_LITERAL      = 5'h0D,
		OP_SKIP_IF_BELOW_LITERAL      = 5'h0E,
		OP_SKIP_IF_NOT_EQUAL_LITERAL  = 5'h0F,
		OP_SKIP_IF_CARRY_CLEAR        = 5'h10,
		OP_SKIP_IF_CARRY_SET          = 5'h11,
		OP_SKIP_IF_ZERO_CLEAR         = 5'h12,
		OP_SKIP_IF_ZERO_SET           = 5'h13,
		OP_SKIP_IF_BIT_CLEAR          = 5'h14,
		OP_WATCHDOG_CLEAR_FIRST_STEP  = 5'h15,
		OP_WATCHDOG_CLEAR_SECOND_STEP = 5'h16,
		OP_HALT                       = 5'h17,
		OP_TABLE_READ                 = 5'h18
	} op_e;

	// ====================
	// sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_FETCH = 3'b010,
		ST_LOAD  = 3'b100
	} state_e;

endpackage

// ===== logic/nibble_alu.sv
// combinational accumulator and flag arithmetic for the literal and rotate operations
`timescale 1ns/1ps
module nibble_alu (
	// operation
	input  wire logic [4:0] op,
	input  wire logic [3:0] lit,
	// current state
	input  wire logic [3:0] acc,
	input  wire logic       carry,
	// results and write enables
	output logic      [3:0] acc_d,
	output logic            acc_we,
	output logic            carry_d,
	output logic            carry_we,
	output logic            zero_d,
	output logic            zero_we
);

	logic [4:0] sum;

	// sum is five bits wide so the carry out is kept
	assign sum = {1'b0, acc} + {1'b0, lit} + {4'h0, carry};

	// one result per operation; anything else leaves every register alone
	always_comb begin
		acc_d    = acc;
		acc_we   = 1'b0;
		carry_d  = carry;
		carry_we = 1'b0;
		zero_we  = 1'b0;
		case (op)
			nibble_exec_pkg::OP_ADD_LITERAL_WITH_CARRY: begin
				{carry_d, acc_d} = sum; // [RULE_01]
				acc_we   = 1'b1;
				carry_we = 1'b1;
				zero_we  = 1'b1;
			end
			nibble_exec_pkg::OP_XOR_LITERAL: begin
				acc_d   = acc ^ lit; // [RULE_02]
				acc_we  = 1'b1;
				zero_we = 1'b1;
			end
			nibble_exec_pkg::OP_AND_LITERAL: begin
				acc_d   = acc & lit; // [RULE_03]
				acc_we  = 1'b1;
				zero_we = 1'b1;
			end
			nibble_exec_pkg::OP_OR_LITERAL: begin
				acc_d   = acc | lit; // [RULE_04]
				acc_we  = 1'b1;
				zero_we = 1'b1;
			end
			nibble_exec_pkg::OP_LOAD_LITERAL_ACC: begin
				acc_d  = lit; // [RULE_05]
				acc_we = 1'b1;
			end
			nibble_exec_pkg::OP_ROTATE_LEFT_PLAIN: begin
				acc_d  = {acc[2:0], acc[3]}; // [RULE_06]
				acc_we = 1'b1;
			end
			nibble_exec_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
				{carry_d, acc_d} = {acc[0], carry, acc[3:1]}; // [RULE_07]
				acc_we   = 1'b1;
				carry_we = 1'b1;
				zero_we  = 1'b1;
			end
			nibble_exec_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
				{carry_d, acc_d} = {acc, carry}; // [RULE_08]
				acc_we   = 1'b1;
				carry_we = 1'b1;
				zero_we  = 1'b1;
			end
			nibble_exec_pkg::OP_CLEAR_CARRY: begin
				carry_d  = 1'b0; // [RULE_09]
				carry_we = 1'b1;
			end
			nibble_exec_pkg::OP_SET_CARRY: begin
				carry_d  = 1'b1; // [RULE_09]
				carry_we = 1'b1;
			end
			nibble_exec_pkg::OP_INCREMENT_ACCUMULATOR: begin
				{carry_d, acc_d} = {1'b0, acc} + 5'h01; // [RULE_10]
				acc_we   = 1'b1;
				carry_we = 1'b1;
				zero_we  = 1'b1;
			end
			nibble_exec_pkg::OP_DECREMENT_ACCUMULATOR: begin
				acc_d    = acc - 4'h1;
				carry_d  = (acc != 4'h0); // [RULE_11] carry means no borrow
				acc_we   = 1'b1;
				carry_we = 1'b1;
				zero_we  = 1'b1;
			end
			default: begin
				acc_we = 1'b0;
			end
		endcase
	end

	// zero reflects the new accumulator value
	assign zero_d = (acc_d == 4'h0); // [RULE_23]

endmodule

// ===== logic/skip_judge.sv
// combinational decision for the conditional skip operations
`timescale 1ns/1ps
module skip_judge (
	// operation
	input  wire logic [4:0] op,
	input  wire logic [3:0] lit,
	// state under test
	input  wire logic [3:0] acc,
	input  wire logic       carry,
	input  wire logic       zero,
	// decision
	output logic            is_skip_op,
	output logic            skip
);

	// compares are unsigned; flags are only read, never written here
	always_comb begin
		is_skip_op = 1'b1;
		skip       = 1'b0;
		case (op)
			nibble_exec_pkg::OP_SKIP_IF_ABOVE_LITERAL:     skip = (acc > lit);        // [RULE_12]
			nibble_exec_pkg::OP_SKIP_IF_BELOW_LITERAL:     skip = (acc < lit);        // [RULE_13]
			nibble_exec_pkg::OP_SKIP_IF_NOT_EQUAL_LITERAL: skip = (acc != lit);       // [RULE_14]
			nibble_exec_pkg::OP_SKIP_IF_CARRY_CLEAR:       skip = (carry == 1'b0);    // [RULE_15]
			nibble_exec_pkg::OP_SKIP_IF_CARRY_SET:         skip = (carry == 1'b1);    // [RULE_15]
			nibble_exec_pkg::OP_SKIP_IF_ZERO_CLEAR:        skip = (zero == 1'b0);     // [RULE_16]
			nibble_exec_pkg::OP_SKIP_IF_ZERO_SET:          skip = (zero == 1'b1);     // [RULE_16]
			nibble_exec_pkg::OP_SKIP_IF_BIT_CLEAR:         skip = ~acc[lit[1:0]];     // [RULE_17]
			default:                                       is_skip_op = 1'b0;
		endcase
	end

endmodule

// ===== logic/nibble_cpu_literal_skip_exec.sv
// executor for literal, rotate, flag, skip, watchdog, halt and table-read instructions
//
// How it works
// [RULE_01] add literal: acc = acc + literal + carry; carry and zero updated; one cycle.
// [RULE_02] xor literal: acc ^= literal; only zero updated, carry kept.
// [RULE_03] and literal: acc &= literal; only zero updated.
// [RULE_04] or literal: acc |= literal; only zero updated.
// [RULE_05] load literal into acc; carry and zero untouched.
// [RULE_06] plain left rotate of acc, bit 3 into bit 0, no flags.
// [RULE_07] right rotate through carry: bit 0 to carry, carry to bit 3.
// [RULE_08] left rotate through carry: bit 3 to carry, carry to bit 0.
// [RULE_09] clear or set carry; zero untouched; one cycle.
// [RULE_10] increment acc; carry set on wrap to zero; zero updated.
// [RULE_11] decrement acc; carry stays 1 unless a borrow occurs.
// [RULE_12] skip next when acc strictly above literal.
// [RULE_13] skip next only when acc strictly below literal; no flags change.
// [RULE_14] skip next when acc differs from literal.
// [RULE_15] skip next when carry is clear or set respectively.
// [RULE_16] skip next when zero flag is clear or set respectively.
// [RULE_17] skip next when accumulator bit selected by 2-bit index is 0.
// [RULE_18] no-operation takes one cycle and changes nothing.
// [RULE_19] watchdog clears only when first step is directly followed by second step.
// [RULE_20] halt takes one cycle, enters sleep and stops the system clock.
// [RULE_21] table read loads word bits into acc, mid and top nibbles in three cycles.
// [RULE_22] borrow is never stored; it is always the inverse of carry.
// [RULE_23] an updated zero flag is 1 exactly when the 4-bit result is zero.
`timescale 1ns/1ps
module nibble_cpu_literal_skip_exec #(
	parameter int unsigned ADDR_W = 11,
	parameter int unsigned WDT_W  = 12
) (
	// clock and reset
	input  wire logic              CLOCK,
	input  wire logic              SRST,
	// instruction port
	input  wire logic              INSTR_VALID,
	input  wire logic [4:0]        INSTR_OP,
	input  wire logic [3:0]        INSTR_LIT,
	output logic                   INSTR_READY,
	output logic                   INSTR_DONE,
	output logic                   INSTR_DISCARDED,
	output logic                   SKIP_PENDING,
	// table memory port
	input  wire logic [ADDR_W-1:0] POINTER_REGISTER,
	output logic      [ADDR_W-1:0] ROM_ADDR,
	output logic                   ROM_RD,
	input  wire logic [9:0]        ROM_DATA,
	// core state
	output logic      [3:0]        ACC,
	output logic                   CARRY,
	output logic                   ZERO,
	output logic                   BORROW,
	output logic      [3:0]        TABLE_MID_NIBBLE,
	output logic      [3:0]        TABLE_TOP_BITS,
	// watchdog
	input  wire logic              WDT_TICK,
	output logic      [WDT_W-1:0]  WATCHDOG_COUNTER,
	output logic                   WDT_ARMED,
	// sleep control
	input  wire logic              WAKE,
	output logic                   HALT_MODE,
	output logic                   SYS_CLK_STOP
);

	// ====================
	// declarations

	nibble_exec_pkg::state_e state_q;
	nibble_exec_pkg::state_e state_d;

	logic [3:0]        acc_q;
	logic              carry_q;
	logic              zero_q;
	logic [3:0]        mid_q;
	logic [3:0]        top_q;
	logic              skip_q;
	logic              wdt_armed_q;
	logic [WDT_W-1:0]  wdt_q;
	logic              halt_q;
	logic              done_q;
	logic              discard_q;
	logic [ADDR_W-1:0] rom_addr_q;
	logic [9:0]        rom_word_q;

	logic       take;
	logic       exec;
	logic       discard;
	logic [4:0] op;

	logic [3:0] alu_acc;
	logic       alu_acc_we;
	logic       alu_carry;
	logic       alu_carry_we;
	logic       alu_zero;
	logic       alu_zero_we;
	logic       is_skip_op;
	logic       skip_now;

	// ====================
	// instruction acceptance

	// a word is only taken in the run state and while awake
	assign INSTR_READY = (state_q == nibble_exec_pkg::ST_RUN) && !halt_q;
	assign take        = INSTR_VALID && INSTR_READY;
	assign op          = INSTR_OP;

	// a pending skip swallows the next word instead of running it
	assign discard = take && skip_q;
	assign exec    = take && !skip_q;

	// ====================
	// arithmetic and skip decision

	nibble_alu u_alu (
		.op       (op),
		.lit      (INSTR_LIT),
		.acc      (acc_q),
		.carry    (carry_q),
		.acc_d    (alu_acc),
		.acc_we   (alu_acc_we),
		.carry_d  (alu_carry),
		.carry_we (alu_carry_we),
		.zero_d   (alu_zero),
		.zero_we  (alu_zero_we)
	);

	skip_judge u_skip (
		.op         (op),
		.lit        (INSTR_LIT),
		.acc        (acc_q),
		.carry      (carry_q),
		.zero       (zero_q),
		.is_skip_op (is_skip_op),
		.skip       (skip_now)
	);

	// ====================
	// table read sequencer

	// next state: run, then issue the address, then load the word
	always_comb begin
		state_d = state_q;
		case (state_q)
			nibble_exec_pkg::ST_RUN: begin
				if (exec && (op == nibble_exec_pkg::OP_TABLE_READ)) begin
					state_d = nibble_exec_pkg::ST_FETCH; // [RULE_21]
				end
			end
			nibble_exec_pkg::ST_FETCH: begin
				state_d = nibble_exec_pkg::ST_LOAD;
			end
			nibble_exec_pkg::ST_LOAD: begin
				state_d = nibble_exec_pkg::ST_RUN;
			end
			default: begin
				state_d = nibble_exec_pkg::ST_RUN;
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			state_q <= nibble_exec_pkg::ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// pointer is captured when the read is taken, so later pointer moves cannot tear it
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rom_addr_q <= '0;
		end else if (exec && (op == nibble_exec_pkg::OP_TABLE_READ)) begin
			rom_addr_q <= POINTER_REGISTER; // [RULE_21]
		end
	end

	// memory answers in the same cycle as the strobe; word is held until the load cycle
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rom_word_q <= 10'h000;
		end else if (state_q == nibble_exec_pkg::ST_FETCH) begin
			rom_word_q <= ROM_DATA;
		end
	end

	assign ROM_ADDR = rom_addr_q;
	assign ROM_RD   = (state_q == nibble_exec_pkg::ST_FETCH);

	// ====================
	// accumulator

	// table read writes acc in its third cycle; literal ops write it at once
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			acc_q <= nibble_exec_pkg::ACC_RESET;
		end else if (state_q == nibble_exec_pkg::ST_LOAD) begin
			acc_q <= rom_word_q[nibble_exec_pkg::ROM_ACC_LSB +: 4]; // [RULE_21]
		end else if (exec && alu_acc_we) begin
			acc_q <= alu_acc; // [RULE_01]
		end
	end

	// ====================
	// flags

	// carry only moves on ops that declare it; skips, nop and table read leave it
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			carry_q <= nibble_exec_pkg::CARRY_RESET;
		end else if (exec && alu_carry_we) begin
			carry_q <= alu_carry; // [RULE_09]
		end
	end

	// zero follows the new result when the op updates it
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			zero_q <= nibble_exec_pkg::ZERO_RESET;
		end else if (exec && alu_zero_we) begin
			zero_q <= alu_zero; // [RULE_23]
		end
	end

	// no separate borrow bit exists, so the two can never disagree
	assign BORROW = ~carry_q; // [RULE_22]

	// ====================
	// table data nibbles

	// the two-bit top field sits in the low bits of its nibble
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			mid_q <= nibble_exec_pkg::MID_RESET;
			top_q <= nibble_exec_pkg::TOP_RESET;
		end else if (state_q == nibble_exec_pkg::ST_LOAD) begin
			mid_q <= rom_word_q[nibble_exec_pkg::ROM_MID_LSB +: 4]; // [RULE_21]
			top_q <= {2'b00, rom_word_q[nibble_exec_pkg::ROM_TOP_LSB +: nibble_exec_pkg::ROM_TOP_W]}; // [RULE_21]
		end
	end

	// ====================
	// skip handling

	// a taken skip marks the following word; that word is then dropped untouched
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			skip_q <= 1'b0;
		end else if (discard) begin
			skip_q <= 1'b0;
		end else if (exec && is_skip_op) begin
			skip_q <= skip_now; // [RULE_12]
		end
	end

	// ====================
	// watchdog

	// any word other than an executed first step breaks the pair, a dropped first step included
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			wdt_armed_q <= 1'b0;
		end else if (take) begin
			wdt_armed_q <= exec && (op == nibble_exec_pkg::OP_WATCHDOG_CLEAR_FIRST_STEP); // [RULE_19]
		end
	end

	// clear beats a tick in the same cycle so a late clear is never undone
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			wdt_q <= '0;
		end else if (exec && wdt_armed_q && (op == nibble_exec_pkg::OP_WATCHDOG_CLEAR_SECOND_STEP)) begin
			wdt_q <= '0; // [RULE_19]
		end else if (WDT_TICK) begin
			wdt_q <= wdt_q + {{(WDT_W-1){1'b0}}, 1'b1};
		end
	end

	// ====================
	// halt

	// sleep holds until the wake input; wake wins only once halted
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			halt_q <= 1'b0;
		end else if (halt_q && WAKE) begin
			halt_q <= 1'b0;
		end else if (exec && (op == nibble_exec_pkg::OP_HALT)) begin
			halt_q <= 1'b1; // [RULE_20]
		end
	end

	// ====================
	// completion strobes

	// done pulses once per executed word; a table read reports in the cycle after its load cycle
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			done_q    <= 1'b0;
			discard_q <= 1'b0;
		end else begin
			done_q    <= (exec && (op != nibble_exec_pkg::OP_TABLE_READ))
			             || (state_q == nibble_exec_pkg::ST_LOAD); // [RULE_18]
			discard_q <= discard;
		end
	end

	// ====================
	// outputs

	assign ACC              = acc_q;
	assign CARRY            = carry_q;
	assign ZERO             = zero_q;
	assign TABLE_MID_NIBBLE = mid_q;
	assign TABLE_TOP_BITS   = top_q;
	assign SKIP_PENDING     = skip_q;
	assign WATCHDOG_COUNTER = wdt_q;
	assign WDT_ARMED        = wdt_armed_q;
	assign HALT_MODE        = halt_q;
	assign SYS_CLK_STOP     = halt_q; // [RULE_20]
	assign INSTR_DONE       = done_q;
	assign INSTR_DISCARDED  = discard_q;

endmodule

// ===== tb/exec_checker_properties.sv
// port checker of the nibble executor, bound into the top module
`timescale 1ns/1ps
module exec_checker #(
	parameter int unsigned WDT_W = 12
) (
	// clock and reset
	input wire logic             CLOCK,
	input wire logic             SRST,
	// instruction port
	input wire logic             INSTR_VALID,
	input wire logic [4:0]       INSTR_OP,
	input wire logic [3:0]       INSTR_LIT,
	input wire logic             INSTR_READY,
	input wire logic             INSTR_DONE,
	input wire logic             INSTR_DISCARDED,
	input wire logic             SKIP_PENDING,
	input wire logic             ROM_RD,
	// core state
	input wire logic [3:0]       ACC,
	input wire logic             CARRY,
	input wire logic             ZERO,
	input wire logic             BORROW,
	input wire logic [WDT_W-1:0] WATCHDOG_COUNTER,
	input wire logic             WDT_ARMED,
	input wire logic             HALT_MODE,
	input wire logic             SYS_CLK_STOP
);
	// ====================
	// helpers: a word that will really execute, adder and rotate images
	logic       run_take;
	logic [4:0] sum5;
	logic [3:0] rot_l;
	assign run_take = INSTR_VALID && INSTR_READY && !SKIP_PENDING;
	assign sum5     = {1'b0, ACC} + {1'b0, INSTR_LIT} + {4'h0, CARRY};
	assign rot_l    = {ACC[2:0], ACC[3]};

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);

	// ====================
	// properties
	property p_borrow;
		BORROW == !CARRY;
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow not inverse of carry");
	property p_add;
		run_take && INSTR_OP == nibble_exec_pkg::OP_ADD_LITERAL_WITH_CARRY |=> {CARRY, ACC} == $past(sum5);
	endproperty
	a_add: assert property (p_add) else $error("add result wrong");
	property p_xor;
		run_take && INSTR_OP == nibble_exec_pkg::OP_XOR_LITERAL |=> ACC == ($past(ACC) ^ $past(INSTR_LIT)) && $stable(CARRY);
	endproperty
	a_xor: assert property (p_xor) else $error("xor result wrong");
	property p_load;
		run_take && INSTR_OP == nibble_exec_pkg::OP_LOAD_LITERAL_ACC |=> ACC == $past(INSTR_LIT) && $stable({CARRY, ZERO});
	endproperty
	a_load: assert property (p_load) else $error("load literal wrong");
	property p_rla;
		run_take && INSTR_OP == nibble_exec_pkg::OP_ROTATE_LEFT_PLAIN |=> ACC == $past(rot_l) && $stable({CARRY, ZERO});
	endproperty
	a_rla: assert property (p_rla) else $error("plain rotate wrong");
	property p_zero;
		run_take && INSTR_OP inside {nibble_exec_pkg::OP_AND_LITERAL, nibble_exec_pkg::OP_OR_LITERAL,
			nibble_exec_pkg::OP_INCREMENT_ACCUMULATOR, nibble_exec_pkg::OP_DECREMENT_ACCUMULATOR}
			|=> ZERO == (ACC == 4'h0);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_skip_flags;
		run_take && INSTR_OP inside {[nibble_exec_pkg::OP_SKIP_IF_ABOVE_LITERAL:nibble_exec_pkg::OP_SKIP_IF_BIT_CLEAR]}
			|=> INSTR_DONE && $stable({ACC, CARRY, ZERO});
	endproperty
	a_skip_flags: assert property (p_skip_flags) else $error("skip changed state");
	property p_drop;
		INSTR_VALID && INSTR_READY && SKIP_PENDING |=> INSTR_DISCARDED && !SKIP_PENDING && $stable({ACC, CARRY});
	endproperty
	a_drop: assert property (p_drop) else $error("skipped word not dropped");
	property p_wdt;
		run_take && WDT_ARMED && INSTR_OP == nibble_exec_pkg::OP_WATCHDOG_CLEAR_SECOND_STEP |=> WATCHDOG_COUNTER == '0;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not cleared");
	property p_table;
		run_take && INSTR_OP == nibble_exec_pkg::OP_TABLE_READ |=> ROM_RD && !INSTR_READY
			##1 !ROM_RD && !INSTR_READY ##1 INSTR_DONE && INSTR_READY && $stable({CARRY, ZERO});
	endproperty
	a_table: assert property (p_table) else $error("table read timing wrong");
	property p_halt;
		run_take && INSTR_OP == nibble_exec_pkg::OP_HALT |=> HALT_MODE && SYS_CLK_STOP && !INSTR_READY;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not entered");

	// ====================
	// main scenarios reached
	c_drop: cover property (INSTR_DISCARDED);
	c_halt: cover property (HALT_MODE);
	c_wdt: cover property (run_take && WDT_ARMED);
endmodule

bind nibble_cpu_literal_skip_exec exec_checker #(.WDT_W(WDT_W)) chk_i (
	.CLOCK(CLOCK), .SRST(SRST), .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP), .INSTR_LIT(INSTR_LIT),
	.INSTR_READY(INSTR_READY), .INSTR_DONE(INSTR_DONE), .INSTR_DISCARDED(INSTR_DISCARDED),
	.SKIP_PENDING(SKIP_PENDING), .ROM_RD(ROM_RD), .ACC(ACC), .CARRY(CARRY), .ZERO(ZERO), .BORROW(BORROW),
	.WATCHDOG_COUNTER(WATCHDOG_COUNTER), .WDT_ARMED(WDT_ARMED), .HALT_MODE(HALT_MODE),
	.SYS_CLK_STOP(SYS_CLK_STOP)
);

// ===== tb/tb.sv
// self-checking bench of the nibble executor against an integer model
`timescale 1ns/1ps
module tb;
	// ====================
	// design connections and model state
	logic        CLOCK, SRST, INSTR_VALID, WDT_TICK, WAKE;
	logic [4:0]  INSTR_OP;
	logic [3:0]  INSTR_LIT, ACC, TABLE_MID_NIBBLE, TABLE_TOP_BITS;
	logic [10:0] POINTER_REGISTER, ROM_ADDR;
	logic [9:0]  ROM_DATA;
	logic [11:0] WATCHDOG_COUNTER;
	logic        INSTR_READY, INSTR_DONE, INSTR_DISCARDED, SKIP_PENDING, ROM_RD;
	logic        CARRY, ZERO, BORROW, WDT_ARMED, HALT_MODE, SYS_CLK_STOP;
	int          err_total, compares, m_wdt, n, k;
	logic [3:0]  m_acc;
	logic        m_c, m_z, m_skip, m_arm;
	logic [4:0]  r_op;

	nibble_cpu_literal_skip_exec #(.ADDR_W(11), .WDT_W(12)) uut (
		.CLOCK(CLOCK), .SRST(SRST), .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP), .INSTR_LIT(INSTR_LIT),
		.INSTR_READY(INSTR_READY), .INSTR_DONE(INSTR_DONE), .INSTR_DISCARDED(INSTR_DISCARDED),
		.SKIP_PENDING(SKIP_PENDING), .POINTER_REGISTER(POINTER_REGISTER), .ROM_ADDR(ROM_ADDR), .ROM_RD(ROM_RD),
		.ROM_DATA(ROM_DATA), .ACC(ACC), .CARRY(CARRY), .ZERO(ZERO), .BORROW(BORROW),
		.TABLE_MID_NIBBLE(TABLE_MID_NIBBLE), .TABLE_TOP_BITS(TABLE_TOP_BITS), .WDT_TICK(WDT_TICK),
		.WATCHDOG_COUNTER(WATCHDOG_COUNTER), .WDT_ARMED(WDT_ARMED), .WAKE(WAKE), .HALT_MODE(HALT_MODE),
		.SYS_CLK_STOP(SYS_CLK_STOP)
	);

	// ====================
	// clock and watchdog model; the model counter wraps like the 12-bit port when sliced
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		if (SRST) m_wdt = 0;
		else if (WDT_TICK) m_wdt = m_wdt + 1;
	end

	// ====================
	// compare and verdict
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ====================
	// one word: model predicts, word is taken at the next edge, results compared a step later
	task automatic exec(input logic [4:0] op, input logic [3:0] l);
		logic       sk;
		logic       drop;
		logic       pair;
		logic       rd;
		logic [9:0] rom;
		drop = m_skip;
		sk = 1'b0;
		pair = !drop && m_arm && op == nibble_exec_pkg::OP_WATCHDOG_CLEAR_SECOND_STEP;
		rd = !drop && op == nibble_exec_pkg::OP_TABLE_READ;
		rom = 10'($urandom);
		INSTR_VALID = 1'b1;
		INSTR_OP = op;
		INSTR_LIT = l;
		WDT_TICK = 1'($urandom);
		POINTER_REGISTER = 11'($urandom);
		ROM_DATA = rom;
		m_arm = !drop && op == nibble_exec_pkg::OP_WATCHDOG_CLEAR_FIRST_STEP;
		if (!drop) begin
			case (op)
				nibble_exec_pkg::OP_ADD_LITERAL_WITH_CARRY: {m_c, m_acc} = m_acc + l + m_c;
				nibble_exec_pkg::OP_XOR_LITERAL: m_acc = m_acc ^ l;
				nibble_exec_pkg::OP_AND_LITERAL: m_acc = m_acc & l;
				nibble_exec_pkg::OP_OR_LITERAL: m_acc = m_acc | l;
				nibble_exec_pkg::OP_LOAD_LITERAL_ACC: m_acc = l;
				nibble_exec_pkg::OP_ROTATE_LEFT_PLAIN: m_acc = {m_acc[2:0], m_acc[3]};
				nibble_exec_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: {m_c, m_acc} = {m_acc[0], m_c, m_acc[3:1]};
				nibble_exec_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: {m_c, m_acc} = {m_acc, m_c};
				nibble_exec_pkg::OP_CLEAR_CARRY: m_c = 1'b0;
				nibble_exec_pkg::OP_SET_CARRY: m_c = 1'b1;
				nibble_exec_pkg::OP_INCREMENT_ACCUMULATOR: {m_c, m_acc} = m_acc + 4'h1;
				nibble_exec_pkg::OP_DECREMENT_ACCUMULATOR: {m_c, m_acc} = {m_acc != 4'h0, m_acc - 4'h1};
				nibble_exec_pkg::OP_SKIP_IF_ABOVE_LITERAL: sk = m_acc > l;
				nibble_exec_pkg::OP_SKIP_IF_BELOW_LITERAL: sk = m_acc < l;
				nibble_exec_pkg::OP_SKIP_IF_NOT_EQUAL_LITERAL: sk = m_acc != l;
				nibble_exec_pkg::OP_SKIP_IF_CARRY_CLEAR: sk = !m_c;
				nibble_exec_pkg::OP_SKIP_IF_CARRY_SET: sk = m_c;
				nibble_exec_pkg::OP_SKIP_IF_ZERO_CLEAR: sk = !m_z;
				nibble_exec_pkg::OP_SKIP_IF_ZERO_SET: sk = m_z;
				nibble_exec_pkg::OP_SKIP_IF_BIT_CLEAR: sk = !m_acc[l[1:0]];
				default: ;
			endcase
			// codes of add, xor, and, or, both carry rotates, increment and decrement rewrite zero
			if (op inside {[5'h01:5'h04], 5'h07, 5'h08, 5'h0B, 5'h0C}) m_z = (m_acc == 4'h0);
		end
		if (rd) m_acc = rom[3:0];
		@(posedge CLOCK);
		#1;
		if (pair) m_wdt = 0;
		if (rd) begin
			chk({ROM_RD, ROM_ADDR}, {1'b1, POINTER_REGISTER});
			INSTR_VALID = 1'b0;
			for (n = 0; n < 4 && INSTR_DONE !== 1'b1; n++) begin
				@(posedge CLOCK);
				#1;
				ROM_DATA = ~rom;
			end
			if (n == 4) begin
				err_total++;
				print_verdict();
			end
			chk({TABLE_MID_NIBBLE, TABLE_TOP_BITS}, {rom[7:4], 2'b00, rom[9:8]});
		end
		chk(ACC, m_acc);
		chk({CARRY, ZERO, BORROW}, {m_c, m_z, !m_c});
		chk({INSTR_DONE, INSTR_DISCARDED, SKIP_PENDING, WDT_ARMED}, {!drop, drop, sk, m_arm});
		chk(WATCHDOG_COUNTER, 12'(m_wdt));
		m_skip = sk;
	endtask

	// ====================
	// main sequence
	initial begin
		SRST = 1'b1;
		INSTR_VALID = 1'b0;
		INSTR_OP = 5'h00;
		INSTR_LIT = 4'h0;
		WDT_TICK = 1'b0;
		WAKE = 1'b0;
		POINTER_REGISTER = 11'h000;
		ROM_DATA = 10'h000;
		err_total = 0;
		compares = 0;
		{m_acc, m_c, m_z, m_skip, m_arm} = 8'h00;
		void'($urandom(8));
		repeat (2) @(posedge CLOCK);
		#1;
		SRST = 1'b0;
		chk({ACC, CARRY, ZERO, INSTR_READY, HALT_MODE, WATCHDOG_COUNTER[3:0]}, 12'h020);
		// worked add example, then watchdog pairing in and out of order
		exec(nibble_exec_pkg::OP_LOAD_LITERAL_ACC, 4'hB);
		exec(nibble_exec_pkg::OP_SET_CARRY, 4'h0);
		exec(nibble_exec_pkg::OP_ADD_LITERAL_WITH_CARRY, 4'h9);
		exec(nibble_exec_pkg::OP_WATCHDOG_CLEAR_FIRST_STEP, 4'h0);
		exec(nibble_exec_pkg::OP_WATCHDOG_CLEAR_SECOND_STEP, 4'h0);
		exec(nibble_exec_pkg::OP_WATCHDOG_CLEAR_SECOND_STEP, 4'h0);
		exec(nibble_exec_pkg::OP_WATCHDOG_CLEAR_FIRST_STEP, 4'h0);
		exec(nibble_exec_pkg::OP_NOP, 4'h0);
		exec(nibble_exec_pkg::OP_WATCHDOG_CLEAR_SECOND_STEP, 4'h0);
		// skip boundaries at equality, then drops of a table read and of a first step
		exec(nibble_exec_pkg::OP_LOAD_LITERAL_ACC, 4'h8);
		exec(nibble_exec_pkg::OP_SKIP_IF_ABOVE_LITERAL, 4'h8);
		exec(nibble_exec_pkg::OP_SKIP_IF_BELOW_LITERAL, 4'h8);
		exec(nibble_exec_pkg::OP_SKIP_IF_NOT_EQUAL_LITERAL, 4'h8);
		exec(nibble_exec_pkg::OP_SKIP_IF_BIT_CLEAR, 4'h3);
		exec(nibble_exec_pkg::OP_SKIP_IF_ABOVE_LITERAL, 4'h7);
		exec(nibble_exec_pkg::OP_TABLE_READ, 4'h0);
		exec(nibble_exec_pkg::OP_SKIP_IF_NOT_EQUAL_LITERAL, 4'h0);
		exec(nibble_exec_pkg::OP_WATCHDOG_CLEAR_FIRST_STEP, 4'h0);
		exec(nibble_exec_pkg::OP_WATCHDOG_CLEAR_SECOND_STEP, 4'h0);
		exec(nibble_exec_pkg::OP_TABLE_READ, 4'h0);
		// random words; unused codes behave as no-op, halt is left to its own scenario
		for (k = 0; k < 400; k++) begin
			r_op = 5'($urandom);
			if (r_op == nibble_exec_pkg::OP_HALT) r_op = nibble_exec_pkg::OP_TABLE_READ;
			exec(r_op, 4'($urandom));
		end
		// halt refuses words until a wake is seen
		if (m_skip) exec(nibble_exec_pkg::OP_NOP, 4'h0);
		exec(nibble_exec_pkg::OP_HALT, 4'h0);
		INSTR_VALID = 1'b0;
		chk({HALT_MODE, SYS_CLK_STOP, INSTR_READY}, 3'b110);
		WAKE = 1'b1;
		@(posedge CLOCK);
		#1;
		WAKE = 1'b0;
		for (n = 0; n < 3 && HALT_MODE !== 1'b0; n++) begin
			@(posedge CLOCK);
			#1;
		end
		chk({HALT_MODE, INSTR_READY}, 2'b01);
		exec(nibble_exec_pkg::OP_INCREMENT_ACCUMULATOR, 4'h0);
		print_verdict();
	end
endmodule
